// ==== verilog/ops_pkg.sv ====
// package for the output protection and operation status block
package ops_pkg;

  // ---------------------------------------------------------------
  // enumerations
  // ---------------------------------------------------------------
  typedef enum logic [1:0] {
    CPL_ALTERNATING = 2'b00,
    CPL_DIRECT      = 2'b01,
    CPL_COMBINED    = 2'b10
  } ops_coupling_t;

  typedef enum logic [1:0] {
    INH_LATCHING = 2'b00,
    INH_LIVE     = 2'b01,
    INH_OFF      = 2'b10
  } ops_inh_mode_t;

  typedef enum logic [1:0] {
    PON_RESET_DEFAULTS = 2'b00,
    PON_RESTORE_SLOT0  = 2'b01,
    PON_POWER_DOWN     = 2'b10
  } ops_pon_t;

  typedef enum logic [3:0] {
    CMD_NONE        = 4'h0,
    CMD_SET_OUTPUT  = 4'h1,
    CMD_SET_COUPLE  = 4'h2,
    CMD_SET_INHMODE = 4'h3,
    CMD_SET_POLAR   = 4'h4,
    CMD_SET_PON     = 4'h5,
    CMD_PROT_CLEAR  = 4'h6,
    CMD_SET_WDOG    = 4'h7,
    CMD_SET_WDELAY  = 4'h8,
    CMD_SET_ENABLE  = 4'h9,
    CMD_SET_RISE    = 4'hA,
    CMD_SET_FALL    = 4'hB,
    CMD_STAT_PRESET = 4'hC,
    CMD_CLEAR_STAT  = 4'hD,
    CMD_RESET       = 4'hE,
    CMD_RECALL      = 4'hF
  } ops_cmd_t;

  typedef enum logic [1:0] {
    RD_EVENT     = 2'b00,
    RD_CONDITION = 2'b01,
    RD_ENABLE    = 2'b10,
    RD_CONTROL   = 2'b11
  } ops_rd_sel_t;

  // ---------------------------------------------------------------
  // carriers
  // ---------------------------------------------------------------
  typedef struct packed {
    ops_cmd_t    op;
    logic [15:0] data;
  } ops_cmd_pkt_t;

  typedef struct packed {
    logic        valid;
    ops_rd_sel_t sel;
  } ops_rd_req_t;

  // saved state slot 0 contents used on restore
  typedef struct packed {
    logic          out_en;
    ops_coupling_t coupling;
    logic          wdog_en;
    logic [11:0]   wdog_delay;
  } ops_saved_t;

  // ---------------------------------------------------------------
  // constants
  // ---------------------------------------------------------------
  localparam int STAT_W = 16;
  localparam int DELAY_W = 12;
  localparam logic [11:0] WDOG_DELAY_MIN = 12'h0001;
  localparam logic [11:0] WDOG_DELAY_MAX = 12'h0E10;
  localparam logic [11:0] WDOG_DELAY_RST = 12'h003C;
  localparam logic [15:0] STAT_ZERO = 16'h0000;
  localparam logic [15:0] RISE_PRESET = 16'hFFFF;
  localparam logic [15:0] FALL_PRESET = 16'h0000;
  localparam logic [15:0] ENABLE_PRESET = 16'h0000;
  // operation condition bit positions
  localparam int COND_OUT_ON = 0;
  localparam int COND_INHIBIT = 1;
  localparam int COND_WDOG_TRIP = 2;
  localparam int COND_PROT_LATCH = 3;
  // control readback field positions
  localparam int CTL_OUT_EN = 0;
  localparam int CTL_COUPLE_LO = 1;
  localparam int CTL_INHMODE_LO = 3;
  localparam int CTL_POLAR = 5;
  localparam int CTL_PON_LO = 6;
  localparam int CTL_WDOG_EN = 8;
  localparam int CTL_INH_FLAG = 9;
  localparam int CTL_PROT_FLAG = 10;
  // timing
  localparam longint CLK_HZ = 64'd10_000_000;
  localparam real TICK_PERIOD_S = 1.0;
  localparam int TICK_CYCLES = int'(TICK_PERIOD_S * real'(CLK_HZ));

endpackage

// ==== verilog/ops_output_protect.sv ====
// output enable, inhibit, watchdog and operation status group
//
// Overview of operation
// - one output enable bit, host writable and readable; reset clears it.
// - coupling select alternating, direct or combined; reset gives alternating.
// - inhibit mode latching, live or off, kept across power cycles.
// - latching: active inhibit forces output off and sets latched flag.
// - after clearing a latch, output stays off until host re-enables.
// - live mode: enabled output follows inhibit input level directly.
// - inhibit mode off: inhibit input never disables the output.
// - selectable polarity decides which inhibit level counts as active.
// - power-on policies defaults, slot zero restore, power-down with output off.
// - power-on policy is nonvolatile; reset and recall leave it alone.
// - protection clear drops latched flags only once all faults are gone.
// - watchdog expiry latches output off, enable bit stays programmed.
// - only remote activity or a cleared enable bit restarts the watchdog, never front panel.
// - watchdog enable bit, host writable and readable; reset clears it.
// - watchdog delay 1 to 3600 whole seconds; reset gives 60.
// - event register latches filtered transitions, clears when read.
// - condition register mirrors live status; reading does not change it.
// - reset clears condition bits except conditions still present.
// - reset leaves event register alone unless it causes a captured edge.
// - enable register masks events; OR of enabled bits is summary bit.
// - status preset clears enable register; enable defaults to zero.
// - clear-status zeroes event register, keeps enable register.
// - rising filter bit captures 0-to-1, falling filter bit 1-to-0.
// - status preset sets rising filter all ones, clears falling filter.

`timescale 1ns/1ps

module ops_output_protect
  import ops_pkg::*;
#(
  parameter int TICK_CYCLES_P = TICK_CYCLES
) (
  // clock and reset
  input wire logic clk_sys_in,
  input wire logic rst_n_in,
  // command port, one-cycle strobe with packet
  input wire logic cmd_valid_in,
  input ops_cmd_pkt_t cmd_in,
  // read port, one-cycle request
  input ops_rd_req_t rd_req_in,
  // external pins and events
  input wire logic inhibit_pin_in,
  input wire logic remote_activity_in,
  input wire logic front_panel_activity_in,
  input wire logic prot_fault_in,
  // power-on sequencing and nonvolatile contents
  input wire logic power_on_in,
  input ops_saved_t saved_slot_in,
  input ops_inh_mode_t nv_inh_mode_in,
  input ops_pon_t nv_pon_in,
  // read answer
  output logic rd_valid_out,
  output logic [15:0] rd_data_out,
  // output control and status
  output logic output_drive_out,
  output ops_coupling_t coupling_out,
  output logic operation_summary_bit_out,
  output ops_inh_mode_t nv_inh_mode_out,
  output ops_pon_t nv_pon_out,
  output logic nv_write_out
);

  // ---------------------------------------------------------------
  // inhibit pin synchroniser
  // ---------------------------------------------------------------
  logic [2:0] inh_sync;
  logic inh_level;
  logic next_inh_level;
  logic inh_active;

  always_comb begin
    next_inh_level = inh_level;
    // change accepted once second and third stages agree
    if (inh_sync[1] == inh_sync[2]) begin
      next_inh_level = inh_sync[2];
    end
  end

  always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      inh_sync <= 3'h0;
      inh_level <= 1'b0;
    end else begin
      inh_sync <= {inh_sync[1:0], inhibit_pin_in};
      inh_level <= next_inh_level;
    end
  end

  // ---------------------------------------------------------------
  // control registers
  // ---------------------------------------------------------------
  logic out_en, next_out_en;
  ops_coupling_t coupling, next_coupling;
  ops_inh_mode_t inh_mode, next_inh_mode;
  logic polarity_neg, next_polarity_neg;
  ops_pon_t pon, next_pon;
  logic wdog_en, next_wdog_en;
  logic [DELAY_W-1:0] wdog_delay, next_wdog_delay;
  logic inh_flag, next_inh_flag;
  logic prot_flag, next_prot_flag;
  logic nv_write, next_nv_write;
  logic wdog_trip;
  logic power_on_d;
  logic pon_pulse;

  logic cmd_go;
  assign cmd_go = cmd_valid_in;
  assign pon_pulse = power_on_in & ~power_on_d;
  assign inh_active = inh_level ^ polarity_neg;

  always_comb begin
    next_out_en = out_en;
    next_coupling = coupling;
    next_inh_mode = inh_mode;
    next_polarity_neg = polarity_neg;
    next_pon = pon;
    next_wdog_en = wdog_en;
    next_wdog_delay = wdog_delay;
    next_inh_flag = inh_flag;
    next_prot_flag = prot_flag;
    next_nv_write = 1'b0;
    if (cmd_go) begin
      case (cmd_in.op)
        CMD_SET_OUTPUT: next_out_en = cmd_in.data[0];
        CMD_SET_COUPLE: begin
          if (cmd_in.data[1:0] != 2'b11) begin
            next_coupling = ops_coupling_t'(cmd_in.data[1:0]);
          end
        end
        CMD_SET_INHMODE: begin
          if (cmd_in.data[1:0] != 2'b11) begin
            next_inh_mode = ops_inh_mode_t'(cmd_in.data[1:0]);
            next_nv_write = 1'b1;
          end
        end
        CMD_SET_POLAR: next_polarity_neg = cmd_in.data[0];
        CMD_SET_PON: begin
          if (cmd_in.data[1:0] != 2'b11) begin
            next_pon = ops_pon_t'(cmd_in.data[1:0]);
            next_nv_write = 1'b1;
          end
        end
        CMD_SET_WDOG: next_wdog_en = cmd_in.data[0];
        CMD_SET_WDELAY: begin
          // out-of-range values are refused, whole seconds only
          if (cmd_in.data[DELAY_W-1:0] >= WDOG_DELAY_MIN &&
              cmd_in.data[DELAY_W-1:0] <= WDOG_DELAY_MAX &&
              cmd_in.data[15:DELAY_W] == 4'h0) begin
            next_wdog_delay = cmd_in.data[DELAY_W-1:0];
          end
        end
        CMD_PROT_CLEAR: begin
          // clear only once every cause is gone; output stays off
          if (!(inh_active && inh_mode == INH_LATCHING) &&
              !prot_fault_in && !wdog_trip) begin
            next_inh_flag = 1'b0;
            next_prot_flag = 1'b0;
            next_out_en = 1'b0;
          end
        end
        CMD_RESET: begin
          next_out_en = 1'b0;
          next_coupling = CPL_ALTERNATING;
          next_wdog_en = 1'b0;
          next_wdog_delay = WDOG_DELAY_RST;
        end
        CMD_RECALL: begin
          next_out_en = saved_slot_in.out_en;
          next_coupling = saved_slot_in.coupling;
          next_wdog_en = saved_slot_in.wdog_en;
          next_wdog_delay = saved_slot_in.wdog_delay;
        end
        default: begin
        end
      endcase
    end
    if (pon_pulse) begin
      next_inh_mode = nv_inh_mode_in;
      next_pon = nv_pon_in;
      case (nv_pon_in)
        PON_RESTORE_SLOT0: begin
          next_out_en = saved_slot_in.out_en;
          next_coupling = saved_slot_in.coupling;
          next_wdog_en = saved_slot_in.wdog_en;
          next_wdog_delay = saved_slot_in.wdog_delay;
        end
        PON_POWER_DOWN: next_out_en = 1'b0;
        default: begin
          next_out_en = 1'b0;
          next_coupling = CPL_ALTERNATING;
          next_wdog_en = 1'b0;
          next_wdog_delay = WDOG_DELAY_RST;
        end
      endcase
    end
    // latch sets win over a same-cycle clear
    if (inh_mode == INH_LATCHING && inh_active) begin
      next_inh_flag = 1'b1;
    end
    if (prot_fault_in || wdog_trip) begin
      next_prot_flag = 1'b1;
    end
  end

  always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      out_en <= 1'b0;
      coupling <= CPL_ALTERNATING;
      inh_mode <= INH_LATCHING;
      polarity_neg <= 1'b0;
      pon <= PON_RESET_DEFAULTS;
      wdog_en <= 1'b0;
      wdog_delay <= WDOG_DELAY_RST;
      inh_flag <= 1'b0;
      prot_flag <= 1'b0;
      nv_write <= 1'b0;
      power_on_d <= 1'b0;
    end else begin
      out_en <= next_out_en;
      coupling <= next_coupling;
      inh_mode <= next_inh_mode;
      polarity_neg <= next_polarity_neg;
      pon <= next_pon;
      wdog_en <= next_wdog_en;
      wdog_delay <= next_wdog_delay;
      inh_flag <= next_inh_flag;
      prot_flag <= next_prot_flag;
      nv_write <= next_nv_write;
      power_on_d <= power_on_in;
    end
  end

  // ---------------------------------------------------------------
  // i/o watchdog
  // ---------------------------------------------------------------
  logic [31:0] tick_cnt, next_tick_cnt;
  logic [DELAY_W-1:0] sec_cnt, next_sec_cnt;
  logic next_wdog_trip;
  logic wdog_restart;

  // front panel activity is deliberately not a restart source
  assign wdog_restart = remote_activity_in | ~wdog_en;

  always_comb begin
    next_tick_cnt = tick_cnt;
    next_sec_cnt = sec_cnt;
    next_wdog_trip = 1'b0;
    if (wdog_restart) begin
      next_tick_cnt = 32'h0000_0000;
      next_sec_cnt = '0;
    end else if (tick_cnt == 32'(TICK_CYCLES_P - 1)) begin
      next_tick_cnt = 32'h0000_0000;
      if (sec_cnt + 1'b1 >= wdog_delay) begin
        next_sec_cnt = '0;
        next_wdog_trip = 1'b1;
      end else begin
        next_sec_cnt = sec_cnt + 1'b1;
      end
    end else begin
      next_tick_cnt = tick_cnt + 32'h0000_0001;
    end
  end

  always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      tick_cnt <= 32'h0000_0000;
      sec_cnt <= '0;
      wdog_trip <= 1'b0;
    end else begin
      tick_cnt <= next_tick_cnt;
      sec_cnt <= next_sec_cnt;
      wdog_trip <= next_wdog_trip;
    end
  end

  // ---------------------------------------------------------------
  // output gating
  // ---------------------------------------------------------------
  logic next_drive;

  always_comb begin
    next_drive = out_en & ~prot_flag & ~inh_flag;
    case (inh_mode)
      INH_LIVE: next_drive = next_drive & ~inh_active;
      INH_LATCHING: next_drive = next_drive & ~inh_active;
      INH_OFF: next_drive = next_drive;
      default: next_drive = 1'b0;
    endcase
  end

  // ---------------------------------------------------------------
  // operation status group
  // ---------------------------------------------------------------
  logic [15:0] cond, next_cond, cond_prev;
  logic [15:0] event_reg, next_event;
  logic [15:0] enable_reg, next_enable;
  logic [15:0] rise_flt, next_rise;
  logic [15:0] fall_flt, next_fall;
  logic next_summary;
  logic [15:0] next_rd_data;
  logic rd_event;

  assign rd_event = rd_req_in.valid && rd_req_in.sel == RD_EVENT;

  always_comb begin
    // live status; after reset only still-present conditions show
    next_cond = STAT_ZERO;
    next_cond[COND_OUT_ON] = next_drive;
    next_cond[COND_INHIBIT] = inh_active && inh_mode != INH_OFF;
    next_cond[COND_WDOG_TRIP] = prot_flag && wdog_en;
    next_cond[COND_PROT_LATCH] = prot_flag | inh_flag;
    next_enable = enable_reg;
    next_rise = rise_flt;
    next_fall = fall_flt;
    next_event = event_reg;
    if (rd_event) begin
      next_event = STAT_ZERO;
    end
    if (cmd_go) begin
      case (cmd_in.op)
        CMD_SET_ENABLE: next_enable = cmd_in.data;
        CMD_SET_RISE: next_rise = cmd_in.data;
        CMD_SET_FALL: next_fall = cmd_in.data;
        CMD_STAT_PRESET: begin
          next_enable = ENABLE_PRESET;
          next_rise = RISE_PRESET;
          next_fall = FALL_PRESET;
        end
        CMD_CLEAR_STAT: next_event = STAT_ZERO;
        default: begin
        end
      endcase
    end
    // reset only reaches the event register through real transitions
    next_event = next_event |
                 (cond & ~cond_prev & rise_flt) |
                 (~cond & cond_prev & fall_flt);
    next_summary = |(event_reg & enable_reg);
    case (rd_req_in.sel)
      RD_EVENT: next_rd_data = event_reg;
      RD_CONDITION: next_rd_data = cond;
      RD_ENABLE: next_rd_data = enable_reg;
      RD_CONTROL: begin
        next_rd_data = STAT_ZERO;
        next_rd_data[CTL_OUT_EN] = out_en;
        next_rd_data[CTL_COUPLE_LO +: 2] = coupling;
        next_rd_data[CTL_INHMODE_LO +: 2] = inh_mode;
        next_rd_data[CTL_POLAR] = polarity_neg;
        next_rd_data[CTL_PON_LO +: 2] = pon;
        next_rd_data[CTL_WDOG_EN] = wdog_en;
        next_rd_data[CTL_INH_FLAG] = inh_flag;
        next_rd_data[CTL_PROT_FLAG] = prot_flag;
      end
      default: next_rd_data = STAT_ZERO;
    endcase
  end

  always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      cond <= STAT_ZERO;
      cond_prev <= STAT_ZERO;
      event_reg <= STAT_ZERO;
      enable_reg <= ENABLE_PRESET;
      rise_flt <= RISE_PRESET;
      fall_flt <= FALL_PRESET;
      operation_summary_bit_out <= 1'b0;
      rd_valid_out <= 1'b0;
      rd_data_out <= STAT_ZERO;
      output_drive_out <= 1'b0;
    end else begin
      cond <= next_cond;
      cond_prev <= cond;
      event_reg <= next_event;
      enable_reg <= next_enable;
      rise_flt <= next_rise;
      fall_flt <= next_fall;
      operation_summary_bit_out <= next_summary;
      rd_valid_out <= rd_req_in.valid;
      rd_data_out <= next_rd_data;
      output_drive_out <= next_drive;
    end
  end

  assign coupling_out = coupling;
  assign nv_inh_mode_out = inh_mode;
  assign nv_pon_out = pon;
  assign nv_write_out = nv_write;

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  a_reset_clears_enable: assert property (
    @(posedge clk_sys_in) disable iff (!rst_n_in)
    (cmd_go && cmd_in.op == CMD_RESET && !pon_pulse) |=> !out_en)
    else $error("reset command left output enabled");

  a_reset_delay_sixty: assert property (
    @(posedge clk_sys_in) disable iff (!rst_n_in)
    (cmd_go && cmd_in.op == CMD_RESET && !pon_pulse)
      |=> wdog_delay == WDOG_DELAY_RST && !wdog_en)
    else $error("reset command did not restore watchdog defaults");

  a_latch_forces_off: assert property (
    @(posedge clk_sys_in) disable iff (!rst_n_in)
    inh_flag |=> !output_drive_out)
    else $error("output driven while inhibit latched");

  a_off_mode_ignores: assert property (
    @(posedge clk_sys_in) disable iff (!rst_n_in)
    (inh_mode == INH_OFF && out_en && !prot_flag && !inh_flag)
      |=> output_drive_out)
    else $error("inhibit off mode still gated the output");

  a_live_follows_pin: assert property (
    @(posedge clk_sys_in) disable iff (!rst_n_in)
    (inh_mode == INH_LIVE && out_en && !prot_flag && !inh_flag)
      |=> output_drive_out == !$past(inh_active))
    else $error("live mode output does not follow inhibit");

  a_read_clears_event: assert property (
    @(posedge clk_sys_in) disable iff (!rst_n_in)
    (rd_event && (cond & ~cond_prev & rise_flt) == STAT_ZERO &&
     (~cond & cond_prev & fall_flt) == STAT_ZERO) |=> event_reg == STAT_ZERO)
    else $error("event register not cleared by read");

  a_summary_is_or: assert property (
    @(posedge clk_sys_in) disable iff (!rst_n_in)
    ##1 operation_summary_bit_out == |($past(event_reg) & $past(enable_reg)))
    else $error("summary bit disagrees with masked events");

  a_preset_filters: assert property (
    @(posedge clk_sys_in) disable iff (!rst_n_in)
    (cmd_go && cmd_in.op == CMD_STAT_PRESET) |=>
      rise_flt == RISE_PRESET && fall_flt == FALL_PRESET &&
      enable_reg == ENABLE_PRESET)
    else $error("status preset left filters or enable wrong");

  a_trip_latches_off: assert property (
    @(posedge clk_sys_in) disable iff (!rst_n_in)
    wdog_trip |=> prot_flag ##1 !output_drive_out)
    else $error("watchdog expiry did not latch output off");

endmodule

// ==== test/ops_host_model.sv ====
// remote host model: sends i/o activity pulses while kept alive
`timescale 1ns/1ps

module ops_host_model (
  // clock and reset
  input wire logic clk_sys_in,
  input wire logic rst_n_in,
  // control from the bench
  input wire logic keepalive_in,
  // remote activity towards the block
  output logic activity_out
);
  logic [2:0] gap;
  logic [2:0] next_gap;

  // one pulse every eight cycles, well inside one watchdog tick
  always_comb begin
    next_gap = keepalive_in ? gap + 3'h1 : 3'h0;
  end

  always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      gap <= 3'h0;
      activity_out <= 1'b0;
    end else begin
      gap <= next_gap;
      activity_out <= keepalive_in && (gap == 3'h7);
    end
  end
endmodule

// ==== test/testbench.sv ====
// self-checking bench for the output protection and status block
`timescale 1ns/1ps

module testbench;
  import ops_pkg::*;
  logic clk_sys_in, rst_n_in, cmd_valid, pin, fp, pon, keep, act, flt;
  ops_cmd_pkt_t cmd;
  ops_rd_req_t rd;
  ops_saved_t slot;
  ops_pon_t nvp, nvp_o;
  ops_inh_mode_t nvm_o, nvm;
  ops_coupling_t cpl;
  logic rv, drv, summ, nvw;
  logic [15:0] rdat;
  int mismatches = 0;
  int tests_run = 0;
  int cyc = 0;

  // ---------------------------------------------------------------
  // design, host and clock
  // ---------------------------------------------------------------
  ops_output_protect #(.TICK_CYCLES_P(10)) i_dut (
    .clk_sys_in(clk_sys_in), .rst_n_in(rst_n_in),
    .cmd_valid_in(cmd_valid), .cmd_in(cmd), .rd_req_in(rd),
    .inhibit_pin_in(pin), .remote_activity_in(act),
    .front_panel_activity_in(fp), .prot_fault_in(flt),
    .power_on_in(pon), .saved_slot_in(slot),
    .nv_inh_mode_in(nvm), .nv_pon_in(nvp),
    .rd_valid_out(rv), .rd_data_out(rdat), .output_drive_out(drv),
    .coupling_out(cpl), .operation_summary_bit_out(summ),
    .nv_inh_mode_out(nvm_o), .nv_pon_out(nvp_o), .nv_write_out(nvw));

  ops_host_model i_host (.clk_sys_in(clk_sys_in), .rst_n_in(rst_n_in),
    .keepalive_in(keep), .activity_out(act));

  initial begin
    clk_sys_in = 1'b0;
    forever #50 clk_sys_in = ~clk_sys_in;
  end

  // ---------------------------------------------------------------
  // tasks
  // ---------------------------------------------------------------
  task automatic complete_run();
    $display("checks %0d mismatches %0d", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask

  task automatic chk(logic [15:0] got, logic [15:0] exp);
    tests_run++;
    if (got !== exp) begin
      mismatches++;
      $display("unexpected at %0t got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic wt(int n);
    repeat (n) @(posedge clk_sys_in);
    #1;
  endtask

  task automatic send(ops_cmd_t op, logic [15:0] d);
    @(posedge clk_sys_in);
    cmd_valid <= 1'b1;
    cmd <= '{op, d};
    @(posedge clk_sys_in);
    cmd_valid <= 1'b0;
  endtask

  // answer is registered on the taking edge and checked just after it
  task automatic rdc(ops_rd_sel_t s, logic [15:0] e);
    @(posedge clk_sys_in);
    rd <= '{1'b1, s};
    @(posedge clk_sys_in);
    rd <= '{1'b0, s};
    #1;
    chk({15'h0000, rv}, 16'h0001);
    chk(rdat, e);
  endtask

  task automatic d(logic e);
    wt(8);
    chk({15'h0000, drv}, {15'h0000, e});
  endtask

  always @(posedge clk_sys_in) begin
    cyc++;
    if (cyc == 20000) begin
      mismatches++;
      complete_run();
    end
  end

  // ---------------------------------------------------------------
  // tests
  // ---------------------------------------------------------------
  initial begin
    rst_n_in = 1'b0;
    cmd_valid = 1'b0;
    cmd = '{CMD_NONE, 16'h0000};
    rd = '{1'b0, RD_EVENT};
    {pin, fp, pon, keep, flt} = 5'h00;
    nvm = INH_LATCHING;
    slot = '{1'b1, CPL_DIRECT, 1'b0, 12'h003C};
    nvp = PON_RESET_DEFAULTS;
    wt(20);
    rst_n_in <= 1'b1;
    rdc(RD_CONTROL, 16'h0000);
    rdc(RD_ENABLE, 16'h0000);
    send(CMD_SET_OUTPUT, 16'h0001);
    d(1'b1);
    for (int i = 0; i < 4; i++) begin
      send(CMD_SET_COUPLE, 16'(i));
      wt(2);
      chk({14'h0000, cpl}, (i < 3) ? 16'(i) : 16'h0002);
    end
    $display("test control done");
    send(CMD_SET_INHMODE, 16'h0001);
    wt(2);
    chk({14'h0000, nvm_o}, 16'h0001);
    pin <= 1'b1;
    d(1'b0);
    pin <= 1'b0;
    d(1'b1);
    send(CMD_SET_POLAR, 16'h0001);
    d(1'b0);
    pin <= 1'b1;
    d(1'b1);
    send(CMD_SET_POLAR, 16'h0000);
    send(CMD_SET_INHMODE, 16'h0002);
    d(1'b1);
    pin <= 1'b0;
    // let the released pin pass the synchroniser before latching is armed
    wt(4);
    send(CMD_SET_INHMODE, 16'h0000);
    pin <= 1'b1;
    d(1'b0);
    rdc(RD_CONTROL, 16'h0205);
    send(CMD_PROT_CLEAR, 16'h0000);
    pin <= 1'b0;
    d(1'b0);
    send(CMD_PROT_CLEAR, 16'h0000);
    rdc(RD_CONTROL, 16'h0004);
    d(1'b0);
    send(CMD_SET_OUTPUT, 16'h0001);
    d(1'b1);
    $display("test inhibit done");
    keep <= 1'b1;
    send(CMD_SET_WDELAY, 16'h0003);
    send(CMD_SET_WDOG, 16'h0001);
    wt(92);
    d(1'b1);
    keep <= 1'b0;
    fp <= 1'b1;
    wt(42);
    d(1'b0);
    rdc(RD_CONTROL, 16'h0505);
    fp <= 1'b0;
    send(CMD_SET_WDOG, 16'h0000);
    flt <= 1'b1;
    send(CMD_PROT_CLEAR, 16'h0000);
    rdc(RD_CONTROL, 16'h0405);
    flt <= 1'b0;
    send(CMD_PROT_CLEAR, 16'h0000);
    send(CMD_SET_OUTPUT, 16'h0000);
    $display("test watchdog done");
    wt(4);
    send(CMD_CLEAR_STAT, 16'h0000);
    send(CMD_SET_ENABLE, 16'h0001);
    send(CMD_SET_OUTPUT, 16'h0001);
    wt(5);
    chk({15'h0000, summ}, 16'h0001);
    rdc(RD_CONDITION, 16'h0001);
    rdc(RD_CONDITION, 16'h0001);
    rdc(RD_EVENT, 16'h0001);
    rdc(RD_EVENT, 16'h0000);
    wt(2);
    chk({15'h0000, summ}, 16'h0000);
    send(CMD_SET_RISE, 16'h0000);
    send(CMD_SET_FALL, 16'h0001);
    send(CMD_SET_OUTPUT, 16'h0000);
    wt(5);
    rdc(RD_CONDITION, 16'h0000);
    send(CMD_CLEAR_STAT, 16'h0000);
    rdc(RD_EVENT, 16'h0000);
    send(CMD_SET_OUTPUT, 16'h0001);
    wt(5);
    rdc(RD_EVENT, 16'h0000);
    send(CMD_SET_OUTPUT, 16'h0000);
    wt(5);
    rdc(RD_EVENT, 16'h0001);
    rdc(RD_ENABLE, 16'h0001);
    send(CMD_STAT_PRESET, 16'h0000);
    rdc(RD_ENABLE, 16'h0000);
    send(CMD_SET_OUTPUT, 16'h0001);
    wt(5);
    rdc(RD_EVENT, 16'h0001);
    $display("test status done");
    send(CMD_SET_PON, 16'h0002);
    #1;
    chk({15'h0000, nvw}, 16'h0001);
    send(CMD_CLEAR_STAT, 16'h0000);
    send(CMD_RESET, 16'h0000);
    d(1'b0);
    rdc(RD_CONTROL, 16'h0080);
    rdc(RD_CONDITION, 16'h0000);
    rdc(RD_EVENT, 16'h0000);
    send(CMD_SET_OUTPUT, 16'h0001);
    nvp <= PON_POWER_DOWN;
    pon <= 1'b1;
    d(1'b0);
    pon <= 1'b0;
    wt(2);
    nvp <= PON_RESTORE_SLOT0;
    nvm <= INH_LIVE;
    pon <= 1'b1;
    d(1'b1);
    chk({14'h0000, cpl}, 16'h0001);
    chk({14'h0000, nvm_o}, 16'h0001);
    send(CMD_RECALL, 16'h0000);
    wt(3);
    chk({14'h0000, nvp_o}, 16'h0001);
    $display("test power-on done");
    complete_run();
  end
endmodule
